// *** verilog/imf_map.vh ***
// register offsets, field positions and reset values of the interrupt mask and flag unit
`ifndef IMF_MAP_VH
`define IMF_MAP_VH
// word indices (byte address = 4 * index)
`define IMF_TIMER_EN 16'hffe2
`define IMF_SERIAL_EN 16'hffe3
`define IMF_KEY0_EN 16'hffe4
`define IMF_KEY12_EN 16'hffe5
`define IMF_TICK_EN 16'hffe6
`define IMF_ADC_EN 16'hffe7
`define IMF_TIMER_PEND 16'hfff2
`define IMF_SERIAL_PEND 16'hfff3
`define IMF_KEY0_PEND 16'hfff4
`define IMF_KEY12_PEND 16'hfff5
`define IMF_TICK_PEND 16'hfff6
`define IMF_ADC_PEND 16'hfff7
// stack pointer write status, read only
`define IMF_GUARD_STAT 16'hfff8
// source bit positions in the 11-bit flag vector
`define IMF_B_T0 0
`define IMF_B_T1 1
`define IMF_B_SER 2
`define IMF_B_K0 3
`define IMF_B_K1 4
`define IMF_B_K2 5
`define IMF_B_16HZ 6
`define IMF_B_8HZ 7
`define IMF_B_2HZ 8
`define IMF_B_1HZ 9
`define IMF_B_ADC 10
`define IMF_NSRC 11
`define IMF_RESET_VAL 11'h000
// vectors
`define IMF_VEC_WDT 4'h0
`define IMF_VEC_TIMER 4'h4
`define IMF_VEC_SERIAL 4'h6
`define IMF_VEC_KEY0 4'h8
`define IMF_VEC_KEY12 4'ha
`define IMF_VEC_TICK 4'hc
`define IMF_VEC_ADC 4'he
`define IMF_VEC_BASE 16'h0100
`endif

// *** verilog/imf_unit.v ***
// interrupt mask and pending flag unit with avalon-mm register slave
// Operation
// - two timer enable bits d1,d0 at ffe2, reset to zero
// - two timer pending flags d1,d0 at fff2, reset to zero
// - serial enable at ffe3 d0, serial pending at fff3 d0, reset zero
// - key group0 enable ffe4 d0; group1 and single at ffe5 d0,d1; flags alike
// - tick 1hz,2hz,8hz,16hz enables d3..d0 at ffe6, flags at fff6
// - adc enable at ffe7 d0, adc pending at fff7 d0, reset zero
// - pending reads one; writing one clears, writing zero keeps
// - unused bits have no storage and read zero
// - flags set on their condition even when masked
// - request repeats while flag stays set
// - after reset all requests blocked until both stack pointers written
// - rewriting one stack pointer blocks all until the other is rewritten
// - fixed vector per source in priority order, watchdog highest, adc lowest
`timescale 1ns/1ps
`include "imf_map.vh"
module imf_unit
(
	// clock and reset
	input wire clk,
	input wire nrst,
	// avalon-mm slave
	input wire [17:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	output reg [1:0] avs_response,
	// interrupt condition pulses from peripherals, same clock
	input wire timer0_event,
	input wire timer1_event,
	input wire serial_event,
	input wire key_group0_event,
	input wire key_group1_event,
	input wire key_single_event,
	input wire tick_16hz_event,
	input wire tick_8hz_event,
	input wire tick_2hz_event,
	input wire tick_1hz_event,
	input wire adc_event,
	input wire watchdog_event,
	// stack pointer write strobes from the core
	input wire wide_stack_pointer_write,
	input wire narrow_stack_pointer_write,
	// cpu side
	output wire irq,
	output wire nmi,
	output reg [15:0] irq_vector,
	output wire irq_out
);

	reg [`IMF_NSRC-1:0] enable;
	reg [`IMF_NSRC-1:0] pending;
	reg wide_set;
	reg narrow_set;
	reg ack;
	reg [`IMF_NSRC-1:0] src_event;
	reg [`IMF_NSRC-1:0] wr_en_mask;
	reg [`IMF_NSRC-1:0] wr_clr;
	reg [`IMF_NSRC-1:0] wr_en_val;
	reg [3:0] rd_val;
	reg rd_hit;
	reg [`IMF_NSRC-1:0] next_pending;
	wire [15:0] word_index;
	wire wr_go;
	wire rd_go;
	wire guard_open;
	wire [`IMF_NSRC-1:0] active;
	wire [3:0] wd;

	// one wait state: request is answered on the second edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign word_index = avs_address[17:2];
	assign wd = avs_byteenable[0] ? avs_writedata[3:0] : 4'h0;
	assign wr_go = avs_write & ack;
	// read data is latched at the first edge so it already stands when waitrequest drops
	assign rd_go = avs_read & ~ack;

	// gather event inputs into one vector
	always @*
	begin
		src_event = `IMF_RESET_VAL;
		src_event[`IMF_B_T0] = timer0_event;
		src_event[`IMF_B_T1] = timer1_event;
		src_event[`IMF_B_SER] = serial_event;
		src_event[`IMF_B_K0] = key_group0_event;
		src_event[`IMF_B_K1] = key_group1_event;
		src_event[`IMF_B_K2] = key_single_event;
		src_event[`IMF_B_16HZ] = tick_16hz_event;
		src_event[`IMF_B_8HZ] = tick_8hz_event;
		src_event[`IMF_B_2HZ] = tick_2hz_event;
		src_event[`IMF_B_1HZ] = tick_1hz_event;
		src_event[`IMF_B_ADC] = adc_event;
	end

	// write decode: which enable bits are written and which flags cleared
	always @*
	begin
		wr_en_mask = `IMF_RESET_VAL;
		wr_en_val = `IMF_RESET_VAL;
		wr_clr = `IMF_RESET_VAL;
		if (wr_go)
		begin
			case (word_index)
				`IMF_TIMER_EN:
				begin
					wr_en_mask[`IMF_B_T1:`IMF_B_T0] = 2'h3;
					wr_en_val[`IMF_B_T1:`IMF_B_T0] = wd[1:0];
				end
				`IMF_SERIAL_EN:
				begin
					wr_en_mask[`IMF_B_SER] = 1'b1;
					wr_en_val[`IMF_B_SER] = wd[0];
				end
				`IMF_KEY0_EN:
				begin
					wr_en_mask[`IMF_B_K0] = 1'b1;
					wr_en_val[`IMF_B_K0] = wd[0];
				end
				`IMF_KEY12_EN:
				begin
					wr_en_mask[`IMF_B_K2:`IMF_B_K1] = 2'h3;
					wr_en_val[`IMF_B_K2:`IMF_B_K1] = wd[1:0];
				end
				`IMF_TICK_EN:
				begin
					wr_en_mask[`IMF_B_1HZ:`IMF_B_16HZ] = 4'hf;
					wr_en_val[`IMF_B_1HZ:`IMF_B_16HZ] = wd;
				end
				`IMF_ADC_EN:
				begin
					wr_en_mask[`IMF_B_ADC] = 1'b1;
					wr_en_val[`IMF_B_ADC] = wd[0];
				end
				`IMF_TIMER_PEND:
				begin
					wr_clr[`IMF_B_T1:`IMF_B_T0] = wd[1:0];
				end
				`IMF_SERIAL_PEND:
				begin
					wr_clr[`IMF_B_SER] = wd[0];
				end
				`IMF_KEY0_PEND:
				begin
					wr_clr[`IMF_B_K0] = wd[0];
				end
				`IMF_KEY12_PEND:
				begin
					wr_clr[`IMF_B_K2:`IMF_B_K1] = wd[1:0];
				end
				`IMF_TICK_PEND:
				begin
					wr_clr[`IMF_B_1HZ:`IMF_B_16HZ] = wd;
				end
				`IMF_ADC_PEND:
				begin
					wr_clr[`IMF_B_ADC] = wd[0];
				end
				default:
				begin
					wr_clr = `IMF_RESET_VAL;
				end
			endcase
		end
	end

	// read decode: unused bit positions read zero
	always @*
	begin
		rd_val = 4'h0;
		rd_hit = 1'b1;
		case (word_index)
			`IMF_TIMER_EN:
			begin
				rd_val = {2'h0, enable[`IMF_B_T1:`IMF_B_T0]};
			end
			`IMF_SERIAL_EN:
			begin
				rd_val = {3'h0, enable[`IMF_B_SER]};
			end
			`IMF_KEY0_EN:
			begin
				rd_val = {3'h0, enable[`IMF_B_K0]};
			end
			`IMF_KEY12_EN:
			begin
				rd_val = {2'h0, enable[`IMF_B_K2:`IMF_B_K1]};
			end
			`IMF_TICK_EN:
			begin
				rd_val = enable[`IMF_B_1HZ:`IMF_B_16HZ];
			end
			`IMF_ADC_EN:
			begin
				rd_val = {3'h0, enable[`IMF_B_ADC]};
			end
			`IMF_TIMER_PEND:
			begin
				rd_val = {2'h0, pending[`IMF_B_T1:`IMF_B_T0]};
			end
			`IMF_SERIAL_PEND:
			begin
				rd_val = {3'h0, pending[`IMF_B_SER]};
			end
			`IMF_KEY0_PEND:
			begin
				rd_val = {3'h0, pending[`IMF_B_K0]};
			end
			`IMF_KEY12_PEND:
			begin
				rd_val = {2'h0, pending[`IMF_B_K2:`IMF_B_K1]};
			end
			`IMF_TICK_PEND:
			begin
				rd_val = pending[`IMF_B_1HZ:`IMF_B_16HZ];
			end
			`IMF_ADC_PEND:
			begin
				rd_val = {3'h0, pending[`IMF_B_ADC]};
			end
			`IMF_GUARD_STAT:
			begin
				rd_val = {1'b0, guard_open, narrow_set, wide_set};
			end
			default:
			begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// flag update: a new event wins over a clear in the same cycle
	always @*
	begin
		next_pending = (pending & ~wr_clr) | src_event;
	end

	// bus acknowledge and read data register
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			ack <= 1'b0;
			avs_readdata <= 32'h0;
			avs_response <= 2'h0;
		end
		else
		begin
			ack <= (avs_read | avs_write) & ~ack;
			if (rd_go)
			begin
				avs_readdata <= {28'h0, rd_val};
				avs_response <= rd_hit ? 2'h0 : 2'h2; // slave error on unmapped read
			end
		end
	end

	// enable and pending storage
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			enable <= `IMF_RESET_VAL;
			pending <= `IMF_RESET_VAL;
		end
		else
		begin
			enable <= (enable & ~wr_en_mask) | (wr_en_val & wr_en_mask);
			pending <= next_pending;
		end
	end

	// stack pointer guard: both must be written, a rewrite closes until the other follows
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			wide_set <= 1'b0;
			narrow_set <= 1'b0;
		end
		else if (wide_stack_pointer_write & narrow_stack_pointer_write)
		begin
			wide_set <= 1'b1;
			narrow_set <= 1'b1;
		end
		else if (wide_stack_pointer_write)
		begin
			wide_set <= 1'b1;
			narrow_set <= guard_open ? 1'b0 : narrow_set;
		end
		else if (narrow_stack_pointer_write)
		begin
			narrow_set <= 1'b1;
			wide_set <= guard_open ? 1'b0 : wide_set;
		end
	end

	assign guard_open = wide_set & narrow_set;

	// request stays high while any enabled flag is set and the stack pointer guard is open
	assign active = pending & enable;
	assign irq = guard_open & (|active);
	assign nmi = guard_open & watchdog_event;
	assign irq_out = irq;

	// vector of highest priority active source
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			irq_vector <= `IMF_VEC_BASE;
		end
		else if (watchdog_event)
		begin
			irq_vector <= `IMF_VEC_BASE | {12'h0, `IMF_VEC_WDT};
		end
		else if (|active[`IMF_B_T1:`IMF_B_T0])
		begin
			irq_vector <= `IMF_VEC_BASE | {12'h0, `IMF_VEC_TIMER};
		end
		else if (active[`IMF_B_SER])
		begin
			irq_vector <= `IMF_VEC_BASE | {12'h0, `IMF_VEC_SERIAL};
		end
		else if (active[`IMF_B_K0])
		begin
			irq_vector <= `IMF_VEC_BASE | {12'h0, `IMF_VEC_KEY0};
		end
		else if (|active[`IMF_B_K2:`IMF_B_K1])
		begin
			irq_vector <= `IMF_VEC_BASE | {12'h0, `IMF_VEC_KEY12};
		end
		else if (|active[`IMF_B_1HZ:`IMF_B_16HZ])
		begin
			irq_vector <= `IMF_VEC_BASE | {12'h0, `IMF_VEC_TICK};
		end
		else
		begin
			irq_vector <= `IMF_VEC_BASE | {12'h0, `IMF_VEC_ADC};
		end
	end

endmodule // imf_unit

// *** verification/imf_cpu_model.sv ***
// cpu core model issuing the stack pointer write strobes
`timescale 1ns/1ps
module imf_cpu_model
(
	// clock
	input wire clk,
	// commands from the bench
	input wire set_wide,
	input wire set_narrow,
	// strobes to the unit
	output reg wide_stack_pointer_write = 1'b0,
	output reg narrow_stack_pointer_write = 1'b0
);
	// one-cycle pointer strobes; each pointer is strobed on its own command, one cycle later
	always @(posedge clk)
	begin
		wide_stack_pointer_write <= set_wide;
		narrow_stack_pointer_write <= set_narrow;
	end
endmodule // imf_cpu_model

// *** verification/imf_unit_properties.sv ***
// assertion checker for the interrupt mask and flag unit
`timescale 1ns/1ps
module imf_unit_properties
(
	// clock and reset
	input wire clk,
	input wire nrst,
	// bus and cpu side
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire [31:0] avs_readdata,
	input wire watchdog_event,
	input wire wide_stack_pointer_write,
	input wire narrow_stack_pointer_write,
	input wire irq,
	input wire nmi
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// request and strobe shorthands
	wire rq = avs_read | avs_write;
	wire sw = wide_stack_pointer_write;
	wire sn = narrow_stack_pointer_write;
	a_wait_first: assert property (rq && !$past(rq) |-> avs_waitrequest) else $error("no wait state");
	a_wait_one: assert property (rq && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
	a_data_high: assert property (avs_readdata[31:4] == 28'h0) else $error("upper bits set");
	a_irq_hold: assert property (irq && !avs_write && !sw && !sn |=> irq) else $error("irq dropped");
	a_nmi_cause: assert property (nmi |-> watchdog_event) else $error("nmi without cause");
	a_guard_reset: assert property ($rose(nrst) |-> !irq && !nmi) else $error("request after reset");
	a_wide_close: assert property (irq && sw && !sn |=> !irq && !nmi) else $error("guard open");
	a_narrow_close: assert property (nmi && sn && !sw |=> !irq && !nmi) else $error("guard open");
	// main scenarios
	c_irq: cover property (irq);
	c_nmi: cover property (nmi);
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule // imf_unit_properties
bind imf_unit imf_unit_properties i_imf_unit_properties (.clk(clk), .nrst(nrst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .irq(irq), .nmi(nmi),
	.watchdog_event(watchdog_event), .wide_stack_pointer_write(wide_stack_pointer_write),
	.narrow_stack_pointer_write(narrow_stack_pointer_write));

// *** verification/imf_unit_tb_top.sv ***
// self-checking bench of the interrupt mask and flag unit
`timescale 1ns/1ps
`include "imf_map.vh"
module imf_unit_tb_top;
	reg clk = 1'b0;
	reg nrst = 1'b0;
	reg [17:0] adr = 18'h0;
	reg rd = 1'b0;
	reg wr = 1'b0;
	reg [31:0] wd = 32'h0;
	reg [10:0] ev = 11'h0;
	reg wdt = 1'b0;
	reg s_w = 1'b0;
	reg s_n = 1'b0;
	wire [31:0] rdata;
	wire wait_n;
	wire [1:0] resp;
	wire irq;
	wire nmi;
	wire [15:0] vec;
	wire irq_out;
	wire sw;
	wire sn;
	integer miscompares = 0;
	integer n_compared = 0;
	reg [15:0] i;
	reg [3:0] q;
	reg [3:0] m [0:5];
	// clock
	initial forever #2.5 clk = ~clk;
	imf_unit i_imf_unit (.clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdata), .avs_waitrequest(wait_n),
		.avs_response(resp), .timer0_event(ev[0]), .timer1_event(ev[1]), .serial_event(ev[2]),
		.key_group0_event(ev[3]), .key_group1_event(ev[4]), .key_single_event(ev[5]), .tick_16hz_event(ev[6]),
		.tick_8hz_event(ev[7]), .tick_2hz_event(ev[8]), .tick_1hz_event(ev[9]), .adc_event(ev[10]),
		.watchdog_event(wdt), .wide_stack_pointer_write(sw), .narrow_stack_pointer_write(sn), .irq(irq),
		.nmi(nmi), .irq_vector(vec), .irq_out(irq_out));
	imf_cpu_model i_imf_cpu_model (.clk(clk), .set_wide(s_w), .set_narrow(s_n),
		.wide_stack_pointer_write(sw), .narrow_stack_pointer_write(sn));
	// verdict
	task tally_and_finish;
	begin
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task chk(input [47:0] nm, input [15:0] e, input [15:0] g);
	begin
		n_compared = n_compared + 1;
		if (g !== e)
		begin
			miscompares = miscompares + 1;
			$display("Error %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	// one bus access; read data taken at the edge where waitrequest is low
	task acc(input w, input [15:0] a, input [3:0] d);
		integer n;
	begin
		adr <= {a, 2'b00};
		wd <= {28'h0, d};
		wr <= w;
		rd <= !w;
		n = 0;
		do
		begin
			@(posedge clk);
			n = n + 1;
		end
		while (wait_n !== 1'b0 && n < 20);
		if (n == 20)
		begin
			miscompares = miscompares + 1;
			tally_and_finish;
		end
		q = rdata[3:0];
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	end
	endtask
	// pointer strobe via the core model, then let the guard settle
	task sp(input w, input n);
	begin
		s_w <= w;
		s_n <= n;
		@(posedge clk);
		s_w <= 1'b0;
		s_n <= 1'b0;
		repeat (2) @(posedge clk);
	end
	endtask
	initial
	begin
		m[0] = 4'h3;
		m[1] = 4'h1;
		m[2] = 4'h1;
		m[3] = 4'h3;
		m[4] = 4'hf;
		m[5] = 4'h1;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		ev <= 11'h7ff;
		@(posedge clk);
		ev <= 11'h0;
		// enables written all ones, flags set while masked
		for (i = 0; i < 6; i = i + 1)
		begin
			acc(1'b0, `IMF_TIMER_EN + i, 4'h0);
			chk("enrst", 16'h0, q);
			acc(1'b1, `IMF_TIMER_EN + i, 4'hf);
			acc(1'b0, `IMF_TIMER_EN + i, 4'h0);
			chk("enable", m[i], q);
			acc(1'b0, `IMF_TIMER_PEND + i, 4'h0);
			chk("flag", m[i], q);
		end
		wdt <= 1'b1;
		chk("guard", 16'h0, {irq, nmi});
		sp(1'b1, 1'b0);
		chk("guard", 16'h0, {irq, nmi});
		sp(1'b0, 1'b1);
		chk("irq", 16'h3, {irq, irq_out});
		sp(1'b1, 1'b0);
		chk("guard", 16'h0, {irq, nmi});
		sp(1'b0, 1'b1);
		chk("guard", 16'h3, {irq, nmi});
		sp(1'b0, 1'b1);
		chk("guard", 16'h0, {irq, nmi});
		sp(1'b1, 1'b0);
		chk("guard", 16'h3, {irq, nmi});
		wdt <= 1'b0;
		repeat (2) @(posedge clk);
		// clear sources in priority order
		for (i = 0; i < 6; i = i + 1)
		begin
			chk("vector", 16'h0104 + {i[14:0], 1'b0}, vec);
			acc(1'b1, `IMF_TIMER_PEND + i, 4'h0);
			acc(1'b0, `IMF_TIMER_PEND + i, 4'h0);
			chk("keep", m[i], q);
			acc(1'b1, `IMF_TIMER_PEND + i, 4'hf);
			acc(1'b0, `IMF_TIMER_PEND + i, 4'h0);
			chk("clear", 16'h0, q);
		end
		chk("irq", 16'h0, irq);
		acc(1'b0, 16'hffe0, 4'h0);
		chk("resp", 16'h2, resp);
		tally_and_finish;
	end
endmodule // imf_unit_tb_top
